/* design/caw_pkg.sv */
// constants, register map and carrier types of the counter array watchdog
// assumes an 8-bit special register bus driven by the core, one access per cycle
package caw_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'hD8;
    localparam logic [7:0] ADDR_MODE = 8'hD9;
    localparam logic [7:0] ADDR_CH2_MODE = 8'hDC;
    localparam logic [7:0] ADDR_CNT_LOW = 8'hF9;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'hFA;
    localparam logic [7:0] ADDR_CH2_OFFSET = 8'hFB;
    localparam logic [7:0] ADDR_CH2_CMP = 8'hFC;

    // ------------------------------------------------------------
    // reset values and fixed patterns
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_FULL = 8'hFF;
    localparam logic [7:0] MODE_RST = 8'h40;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam logic [2:0] FLAGS_ZERO = 3'h0;

    // ------------------------------------------------------------
    // divider terminal counts
    // ------------------------------------------------------------
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] EXT_DIV_LAST = 4'h7;
    localparam logic [3:0] DIV_ZERO = 4'h0;
    localparam logic [3:0] DIV_STEP = 4'h1;

    // ------------------------------------------------------------
    // timebase selection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TB_SYS_DIV12 = 3'b000,
        TB_SYS_DIV4 = 3'b001,
        TB_TIMER0_OVF = 3'b010,
        TB_EXT_FALL = 3'b011,
        TB_SYS = 3'b100,
        TB_EXT_DIV8 = 3'b101,
        TB_RSVD6 = 3'b110,
        TB_RSVD7 = 3'b111
    } caw_tb_e;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic idle_suspend;
        logic wd_enable_bit;
        logic wd_lock_bit;
        logic unused;
        caw_tb_e timebase_select;
        logic ovf_irq_en;
    } caw_mode_s;

    typedef struct packed {
        logic overflow_flag;
        logic run_control;
        logic [2:0] rsvd;
        logic ch2_flag;
        logic ch1_flag;
        logic ch0_flag;
    } caw_ctrl_s;

    typedef struct packed {
        logic pwm16;
        logic cmp_en;
        logic cap_pos;
        logic cap_neg;
        logic match_en;
        logic toggle;
        logic pwm;
        logic flag_irq_en;
    } caw_ch_mode_s;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } caw_sfr_req_s;

endpackage

/* design/caw_timebase.sv */
// counter clock source selection: emits one-cycle tick enables
// assumes timer 0 overflow, external input and external clock are synchronous levels
`timescale 1ns/10ps

module caw_timebase (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // selection
    input wire caw_pkg::caw_tb_e sel_in,
    // sources
    input wire logic timer0_ovf_in,
    input wire logic ext_input_in,
    input wire logic ext_clk_in,
    // tick enable
    output logic tick_out
);

    logic [3:0] div12_reg;
    logic [3:0] div4_reg;
    logic [3:0] ext_div_reg;
    logic ext_input_prev_reg;
    logic ext_clk_prev_reg;
    logic div12_end;
    logic div4_end;
    logic ext_fall;
    logic ext_rise;
    logic ext_div_end;
    logic tick_next;

    // ------------------------------------------------------------
    // dividers and edge detectors
    // ------------------------------------------------------------
    assign div12_end = (div12_reg == caw_pkg::DIV12_LAST);
    assign div4_end = (div4_reg == caw_pkg::DIV4_LAST);
    assign ext_fall = ext_input_prev_reg & ~ext_input_in;
    assign ext_rise = ~ext_clk_prev_reg & ext_clk_in;
    assign ext_div_end = ext_rise & (ext_div_reg == caw_pkg::EXT_DIV_LAST);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div12_reg <= caw_pkg::DIV_ZERO;
            div4_reg <= caw_pkg::DIV_ZERO;
            ext_div_reg <= caw_pkg::DIV_ZERO;
            ext_input_prev_reg <= 1'b0;
            // rise detector starts high so a clock idling high gives no false edge after reset
            ext_clk_prev_reg <= 1'b1;
        end else begin
            div12_reg <= div12_end ? caw_pkg::DIV_ZERO : div12_reg + caw_pkg::DIV_STEP;
            div4_reg <= div4_end ? caw_pkg::DIV_ZERO : div4_reg + caw_pkg::DIV_STEP;
            if (ext_rise) begin
                ext_div_reg <= ext_div_end ? caw_pkg::DIV_ZERO : ext_div_reg + caw_pkg::DIV_STEP;
            end
            ext_input_prev_reg <= ext_input_in;
            ext_clk_prev_reg <= ext_clk_in;
        end
    end

    // ------------------------------------------------------------
    // source select
    // ------------------------------------------------------------
    // timebase source decode
    always_comb begin
        case (sel_in)
            caw_pkg::TB_SYS_DIV12: tick_next = div12_end;
            caw_pkg::TB_SYS_DIV4: tick_next = div4_end;
            caw_pkg::TB_TIMER0_OVF: tick_next = timer0_ovf_in;
            caw_pkg::TB_EXT_FALL: tick_next = ext_fall;
            caw_pkg::TB_SYS: tick_next = 1'b1;
            caw_pkg::TB_EXT_DIV8: tick_next = ext_div_end;
            default: tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_next;
        end
    end

endmodule

/* design/caw_counter.sv */
// 16-bit counter with byte loads and overflow indications
// assumes the parent gates loads and decides when it runs
`timescale 1ns/10ps

module caw_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // control
    input wire logic step_in,
    input wire logic load_low_in,
    input wire logic load_high_in,
    input wire logic [7:0] wdata_in,
    // state
    output logic [WIDTH-1:0] count_out,
    output logic low_ovf_out,
    output logic wrap_out
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // ------------------------------------------------------------
    // count
    // ------------------------------------------------------------
    assign low_ovf_out = step_in & (count_reg[7:0] == caw_pkg::BYTE_FULL);
    assign wrap_out = step_in & (count_reg == caw_pkg::CNT_FULL);
    assign count_out = count_reg;

    always_comb begin
        count_next = step_in ? WIDTH'(count_reg + 1'b1) : count_reg;
        if (load_low_in) begin
            count_next[7:0] = wdata_in;
        end
        if (load_high_in) begin
            count_next[15:8] = wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

/* design/caw_watchdog.sv */
// counter array control and flags, with channel 2 acting as the supervision timer
// assumes the core presents one register access per cycle on sfr_req_in
// and that system reset comes back through rst_in after wd_reset_out
`timescale 1ns/10ps

module caw_watchdog (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register bus
    input wire caw_pkg::caw_sfr_req_s sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    // counter sources and system state
    input wire logic timer0_ovf_in,
    input wire logic ext_input_in,
    input wire logic ext_clk_in,
    input wire logic cpu_idle_in,
    // channel 0 and 1 events and their interrupt enables
    input wire logic [1:0] ch_event_in,
    input wire logic [1:0] ch_irq_en_in,
    // results
    output logic irq_out,
    output logic wd_reset_out,
    output logic wd_active_out
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input caw_pkg::caw_sfr_req_s req, input logic [7:0] addr);
        wr_hit = req.wr & (req.addr == addr);
    endfunction

    function automatic logic rd_hit(input caw_pkg::caw_sfr_req_s req, input logic [7:0] addr);
        rd_hit = req.rd & (req.addr == addr);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    caw_pkg::caw_mode_s mode_reg;
    caw_pkg::caw_mode_s mode_next;
    caw_pkg::caw_ch_mode_s ch2_mode_reg;
    caw_pkg::caw_ch_mode_s ch2_mode_next;
    caw_pkg::caw_ctrl_s wdata_ctrl;
    caw_pkg::caw_mode_s wdata_mode;
    caw_pkg::caw_ctrl_s ctrl_view;
    logic overflow_flag_reg;
    logic overflow_flag_next;
    logic run_control_reg;
    logic [2:0] ch_flags_reg;
    logic [2:0] ch_flags_next;
    logic [2:0] ch_flags_set;
    logic [7:0] ch2_offset_reg;
    logic [7:0] ch2_cmp_reg;
    logic [7:0] ch2_cmp_next;
    logic [7:0] rdata_next;
    logic irq_next;
    logic wd_reset_next;

    // ------------------------------------------------------------
    // named wires
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_mode;
    logic wr_ch2_mode;
    logic wr_low;
    logic wr_high;
    logic wr_offset;
    logic wr_cmp;
    logic rd_any;
    logic wd_en;
    logic suspended;
    logic run;
    logic tick;
    logic step;
    logic [15:0] count;
    logic low_ovf;
    logic wrap;
    logic ch2_match;
    logic wd_timeout;
    logic wd_force;

    assign wdata_ctrl = caw_pkg::caw_ctrl_s'(sfr_req_in.wdata);
    assign wdata_mode = caw_pkg::caw_mode_s'(sfr_req_in.wdata);
    assign wr_ctrl = wr_hit(sfr_req_in, caw_pkg::ADDR_CTRL);
    assign wr_mode = wr_hit(sfr_req_in, caw_pkg::ADDR_MODE);
    assign wr_ch2_mode = wr_hit(sfr_req_in, caw_pkg::ADDR_CH2_MODE);
    assign wr_offset = wr_hit(sfr_req_in, caw_pkg::ADDR_CH2_OFFSET);
    assign wr_cmp = wr_hit(sfr_req_in, caw_pkg::ADDR_CH2_CMP);
    assign rd_any = sfr_req_in.rd;

    assign wd_en = mode_reg.wd_enable_bit | mode_reg.wd_lock_bit;

    assign wr_low = wr_hit(sfr_req_in, caw_pkg::ADDR_CNT_LOW) & ~wd_en;
    assign wr_high = wr_hit(sfr_req_in, caw_pkg::ADDR_CNT_HIGH) & ~wd_en;

    // ------------------------------------------------------------
    // counter clocking
    // ------------------------------------------------------------
    // idle suspension applies with or without the timer, so a suspended core
    // also stops the timeout when software asked for that
    assign suspended = mode_reg.idle_suspend & cpu_idle_in;
    assign run = (run_control_reg | wd_en) & ~suspended;
    assign step = tick & run;

    caw_timebase u_timebase (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sel_in(mode_reg.timebase_select),
        .timer0_ovf_in(timer0_ovf_in),
        .ext_input_in(ext_input_in),
        .ext_clk_in(ext_clk_in),
        .tick_out(tick)
    );

    caw_counter #(
        .WIDTH(16)
    ) u_counter (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .step_in(step),
        .load_low_in(wr_low),
        .load_high_in(wr_high),
        .wdata_in(sfr_req_in.wdata),
        .count_out(count),
        .low_ovf_out(low_ovf),
        .wrap_out(wrap)
    );

    // ------------------------------------------------------------
    // channel 2 compare and timeout
    // ------------------------------------------------------------
    // plain compare only outside timer use
    assign ch2_match = step & ~wd_en & ch2_mode_reg.cmp_en & ch2_mode_reg.match_en &
                       ({ch2_cmp_reg, ch2_offset_reg} == count);
    assign wd_timeout = wd_en & low_ovf & (count[15:8] == ch2_cmp_reg);
    assign wd_force = wd_en & wr_ctrl & wdata_ctrl.ch2_flag;
    assign wd_reset_next = wd_timeout | wd_force;

    // update write loads high plus offset
    assign ch2_cmp_next = wr_cmp ? (wd_en ? 8'(count[15:8] + ch2_offset_reg) : sfr_req_in.wdata) : ch2_cmp_reg;

    // ------------------------------------------------------------
    // mode register write
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        if (wr_mode) begin
            mode_next.wd_enable_bit = wdata_mode.wd_enable_bit;
            if (!mode_reg.wd_enable_bit) begin
                mode_next.ovf_irq_en = wdata_mode.ovf_irq_en;
                mode_next.wd_lock_bit = mode_reg.wd_lock_bit | wdata_mode.wd_lock_bit;
                if (!wd_en) begin
                    mode_next.timebase_select = wdata_mode.timebase_select;
                    mode_next.idle_suspend = wdata_mode.idle_suspend;
                end
            end
        end
        mode_next.unused = 1'b0;
    end

    // ------------------------------------------------------------
    // channel 2 mode register
    // ------------------------------------------------------------
    always_comb begin
        ch2_mode_next = ch2_mode_reg;
        if (!wd_en) begin
            if (wr_ch2_mode) begin
                ch2_mode_next = caw_pkg::caw_ch_mode_s'(sfr_req_in.wdata);
            end
            // a 16-bit compare value is written low byte first
            if (wr_offset) begin
                ch2_mode_next.cmp_en = 1'b0;
            end
            if (wr_cmp) begin
                ch2_mode_next.cmp_en = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control flags, set wins over clear
    // ------------------------------------------------------------
    // hardware sets channel flags
    assign ch_flags_set = {ch2_match, ch_event_in};
    assign overflow_flag_next = (wr_ctrl ? wdata_ctrl.overflow_flag : overflow_flag_reg) | wrap;
    assign ch_flags_next = (wr_ctrl ? {wdata_ctrl.ch2_flag, wdata_ctrl.ch1_flag, wdata_ctrl.ch0_flag}
                                    : ch_flags_reg) | ch_flags_set;

    assign irq_next = (overflow_flag_reg & mode_reg.ovf_irq_en) |
                      (ch_flags_reg[2] & ch2_mode_reg.flag_irq_en) |
                      (|(ch_flags_reg[1:0] & ch_irq_en_in));

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    // software run bit, zero gap
    assign ctrl_view = '{overflow_flag: overflow_flag_reg, run_control: run_control_reg, rsvd: caw_pkg::FLAGS_ZERO,
                         ch2_flag: ch_flags_reg[2], ch1_flag: ch_flags_reg[1], ch0_flag: ch_flags_reg[0]};

    always_comb begin
        rdata_next = caw_pkg::BYTE_ZERO;
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CTRL)) begin
            rdata_next = ctrl_view;
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_MODE)) begin
            rdata_next = mode_reg;
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CH2_MODE)) begin
            rdata_next = ch2_mode_reg;
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CNT_LOW)) begin
            rdata_next = count[7:0];
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CNT_HIGH)) begin
            rdata_next = count[15:8];
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CH2_OFFSET)) begin
            rdata_next = ch2_offset_reg;
        end
        if (rd_hit(sfr_req_in, caw_pkg::ADDR_CH2_CMP)) begin
            rdata_next = ch2_cmp_reg;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // enabled at reset, zero offset
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_reg <= caw_pkg::caw_mode_s'(caw_pkg::MODE_RST);
            ch2_mode_reg <= caw_pkg::caw_ch_mode_s'(caw_pkg::BYTE_ZERO);
            ch2_offset_reg <= caw_pkg::BYTE_ZERO;
            ch2_cmp_reg <= caw_pkg::BYTE_ZERO;
        end else begin
            mode_reg <= mode_next;
            ch2_mode_reg <= ch2_mode_next;
            ch2_cmp_reg <= ch2_cmp_next;
            if (wr_offset) begin
                ch2_offset_reg <= sfr_req_in.wdata;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            overflow_flag_reg <= 1'b0;
            run_control_reg <= 1'b0;
            ch_flags_reg <= caw_pkg::FLAGS_ZERO;
        end else begin
            overflow_flag_reg <= overflow_flag_next;
            ch_flags_reg <= ch_flags_next;
            if (wr_ctrl) begin
                run_control_reg <= wdata_ctrl.run_control;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= caw_pkg::BYTE_ZERO;
            irq_out <= 1'b0;
            wd_reset_out <= 1'b0;
            wd_active_out <= 1'b1;
        end else begin
            if (rd_any) begin
                sfr_rdata_out <= rdata_next;
            end
            irq_out <= irq_next;
            wd_reset_out <= wd_reset_next;
            wd_active_out <= mode_next.wd_enable_bit | mode_next.wd_lock_bit;
        end
    end

endmodule

/* dv/caw_watchdog_checker.sv */
// checker for the counter array watchdog top ports
// assumes bind onto caw_watchdog, one clock domain
`timescale 1ns/10ps

module caw_watchdog_checker (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // watched ports
    input wire caw_pkg::caw_sfr_req_s sfr_req_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic [1:0] ch_event_in,
    input wire logic [1:0] ch_irq_en_in,
    input wire logic irq_out,
    input wire logic wd_reset_out,
    input wire logic wd_active_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    wire logic wr_ctrl = sfr_req_in.wr && sfr_req_in.addr == caw_pkg::ADDR_CTRL;
    wire logic wr_mode = sfr_req_in.wr && sfr_req_in.addr == caw_pkg::ADDR_MODE;
    wire logic wr_off = wr_mode && !sfr_req_in.wdata[6];
    wire logic wr_on = wr_mode && (sfr_req_in.wdata[6] || sfr_req_in.wdata[5]);

    chk_pulse_one_cycle: assert property (wd_reset_out |=> !wd_reset_out)
        else $error("reset request wider than one cycle");
    chk_force_reset_now: assert property (wr_ctrl && sfr_req_in.wdata[2] && wd_active_out |=> wd_reset_out)
        else $error("forced reset missing");
    chk_reset_when_active: assert property (wd_reset_out |-> $past(wd_active_out))
        else $error("reset request while timer off");
    chk_ctrl_rsvd_zero: assert property (sfr_req_in.rd && sfr_req_in.addr == caw_pkg::ADDR_CTRL
        |=> sfr_rdata_out[5:3] == 3'h0)
        else $error("control bits 5 to 3 not zero");
    chk_mode_unused_zero: assert property (sfr_req_in.rd && sfr_req_in.addr == caw_pkg::ADDR_MODE
        |=> sfr_rdata_out[4] == 1'b0)
        else $error("mode bit 4 not zero");
    chk_active_falls_cause: assert property ($fell(wd_active_out) |-> $past(wr_off) || $past(wr_off, 2))
        else $error("timer disabled without a write");
    chk_active_rises_cause: assert property ($rose(wd_active_out) |-> $past(wr_on) || $past(wr_on, 2))
        else $error("timer enabled without a write");
    chk_flag_irq_soon: assert property (ch_event_in[0] && ch_irq_en_in[0] |-> ##[1:2] irq_out)
        else $error("channel flag interrupt missing");
    chk_rdata_holds: assert property (!sfr_req_in.rd |=> $stable(sfr_rdata_out))
        else $error("read data moved without a read");
endmodule

bind caw_watchdog caw_watchdog_checker u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .ch_event_in(ch_event_in),
    .ch_irq_en_in(ch_irq_en_in), .irq_out(irq_out), .wd_reset_out(wd_reset_out),
    .wd_active_out(wd_active_out));

/* dv/caw_watchdog_test.sv */
// self-checking bench for the counter array watchdog
// assumes the bench feeds each reset request back on rst_in
`timescale 1ns/10ps

module caw_watchdog_test;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    caw_pkg::caw_sfr_req_s req = '0;
    logic [7:0] rdata;
    logic [1:0] ch_event = 2'h0;
    logic [1:0] ch_irq_en = 2'h0;
    logic t0_ovf = 1'b0;
    logic ext_in = 1'b1;
    logic irq;
    logic wd_reset;
    logic wd_active;
    logic rd_seen = 1'b0;
    logic [15:0] note;
    logic [15:0] note_q[$];
    logic [7:0] lfsr = 8'h62;
    logic [7:0] r1;
    logic [7:0] r2;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    // external clock and idle stay quiet
    caw_watchdog dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
        .timer0_ovf_in(t0_ovf), .ext_input_in(ext_in), .ext_clk_in(1'b0), .cpu_idle_in(1'b0),
        .ch_event_in(ch_event), .ch_irq_en_in(ch_irq_en), .irq_out(irq), .wd_reset_out(wd_reset),
        .wd_active_out(wd_active));

    always #4 core_clk_in = ~core_clk_in;

    // ----------------------------------------
    // comparisons and closing
    // ----------------------------------------
    task automatic compare(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        check_count++;
        if (((got ^ exp) & mask) !== 8'h00) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic compare_time(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // bus and reset tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk_in);
        req.addr = addr;
        req.wdata = data;
        req.wr = 1'b1;
        @(negedge core_clk_in);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask);
        @(negedge core_clk_in);
        req.addr = addr;
        req.rd = 1'b1;
        note_q.push_back({mask, exp});
        @(negedge core_clk_in);
        req.rd = 1'b0;
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b0;
    endtask

    // counts cycles to the reset request, then feeds it back as system reset
    task automatic wait_reset(input int lo, input int hi);
        int n;
        n = 0;
        while (wd_reset !== 1'b1 && n < hi + 8) begin
            @(negedge core_clk_in);
            n++;
        end
        compare_time(n, lo, hi);
        do_reset();
    endtask

    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    always @(posedge core_clk_in) begin
        rd_seen <= req.rd;
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            end_of_test();
        end
    end

    always @(negedge core_clk_in) begin
        if (rd_seen) begin
            note = note_q.pop_front();
            compare(rdata, note[7:0], note[15:8]);
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        do_reset();
        compare({7'h0, wd_active}, 8'h01, 8'hFF);
        wait_reset(3068, 3080);
        rd(caw_pkg::ADDR_MODE, caw_pkg::MODE_RST, 8'hFF);
        rd(caw_pkg::ADDR_CTRL, 8'h00, 8'hFF);
        wr(caw_pkg::ADDR_MODE, 8'hEB);
        rd(caw_pkg::ADDR_MODE, caw_pkg::MODE_RST, 8'hFF);
        wr(caw_pkg::ADDR_CH2_MODE, 8'hFF);
        rd(caw_pkg::ADDR_CH2_MODE, 8'h00, 8'hB7);
        wr(caw_pkg::ADDR_CTRL, 8'h04);
        wait_reset(0, 2);
        wr(caw_pkg::ADDR_MODE, 8'h00);
        wr(caw_pkg::ADDR_MODE, 8'h08);
        wr(caw_pkg::ADDR_CH2_OFFSET, 8'h01);
        wr(caw_pkg::ADDR_CNT_LOW, 8'hF0);
        rd(caw_pkg::ADDR_CNT_LOW, 8'hF0, 8'hFF);
        wr(caw_pkg::ADDR_MODE, 8'h48);
        wr(caw_pkg::ADDR_CH2_CMP, 8'h5A);
        rd(caw_pkg::ADDR_CH2_CMP, 8'h01, 8'hFF);
        wr(caw_pkg::ADDR_CNT_LOW, 8'h00);
        rd(caw_pkg::ADDR_CTRL, 8'h00, 8'h40);
        wr(caw_pkg::ADDR_CTRL, 8'h00);
        // a counter write that landed would add 246 ticks
        wait_reset(254, 271);
        wr(caw_pkg::ADDR_MODE, 8'h00);
        compare({7'h0, wd_active}, 8'h00, 8'hFF);
        wr(caw_pkg::ADDR_MODE, 8'h20);
        wr(caw_pkg::ADDR_MODE, 8'h00);
        rd(caw_pkg::ADDR_MODE, 8'h20, 8'hFF);
        compare({7'h0, wd_active}, 8'h01, 8'hFF);
        do_reset();
        wr(caw_pkg::ADDR_MODE, 8'h00);
        ch_irq_en = 2'h1;
        ch_event = 2'h1;
        @(negedge core_clk_in);
        ch_event = 2'h0;
        rd(caw_pkg::ADDR_CTRL, 8'h01, 8'hFF);
        compare({7'h0, irq}, 8'h01, 8'hFF);
        wr(caw_pkg::ADDR_CTRL, 8'h38);
        rd(caw_pkg::ADDR_CTRL, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            r1 = lfsr;
            lfsr = next_rand(lfsr);
            r2 = lfsr;
            wr(caw_pkg::ADDR_CNT_LOW, r1);
            wr(caw_pkg::ADDR_CNT_HIGH, r2);
            rd(caw_pkg::ADDR_CNT_LOW, r1, 8'hFF);
            rd(caw_pkg::ADDR_CNT_HIGH, r2, 8'hFF);
        end
        wr(caw_pkg::ADDR_CNT_LOW, 8'hFC);
        wr(caw_pkg::ADDR_CNT_HIGH, 8'hFF);
        wr(caw_pkg::ADDR_MODE, 8'h08);
        wr(caw_pkg::ADDR_CTRL, 8'h40);
        repeat (10) @(negedge core_clk_in);
        rd(caw_pkg::ADDR_CTRL, 8'hC0, 8'hC0);
        // timer 0 overflow pulses, then external falling edges, one count each
        wr(caw_pkg::ADDR_MODE, 8'h04);
        wr(caw_pkg::ADDR_CNT_LOW, 8'h00);
        repeat (5) begin
            @(negedge core_clk_in);
            t0_ovf = 1'b1;
            @(negedge core_clk_in);
            t0_ovf = 1'b0;
        end
        rd(caw_pkg::ADDR_CNT_LOW, 8'h05, 8'hFF);
        wr(caw_pkg::ADDR_MODE, 8'h06);
        wr(caw_pkg::ADDR_CNT_LOW, 8'h00);
        repeat (3) begin
            @(negedge core_clk_in);
            ext_in = 1'b0;
            @(negedge core_clk_in);
            ext_in = 1'b1;
        end
        rd(caw_pkg::ADDR_CNT_LOW, 8'h03, 8'hFF);
        repeat (2) @(negedge core_clk_in);
        end_of_test();
    end
endmodule
